//--- design/odt_and_dqs_timer_mode_regs.sv
// Termination mode register (two set-point copies) and the DQS interval timer run-time register.
// Assumes commands already decoded into same-clock strobes; set-point bits come from the
// frequency set-point register in the same clock domain.
`timescale 1ns/1ps

module odt_and_dqs_timer_mode_regs
    import odt_timer_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       mrw_valid,
    input  wire logic       mrr_valid,
    input  wire logic [5:0] mr_addr,
    input  wire logic [7:0] mr_wdata,
    input  wire logic       write_target_set_point,
    input  wire logic       operating_set_point,
    input  wire logic       io_pull_up_cal,
    input  wire logic       mpc_valid,
    input  wire logic [6:0] mpc_opcode,
    input  wire logic       osc_start,
    output logic [7:0]      mr_rdata,
    output logic            mr_rvalid,
    output logic [2:0]      controller_termination_value,
    output logic            clock_termination_disable,
    output logic            chip_select_termination_disable,
    output logic            command_address_termination_disable,
    output logic            osc_running,
    output logic            osc_count_clear,
    output logic            illegal_term_write
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [5:0]  term_sp0;
        logic [5:0]  term_sp1;
        logic [7:0]  run_time;
        logic        running;
        logic [13:0] elapsed;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [5:0]  active;
        logic        count_clear;
        logic        illegal;
    } state_type;

    state_type s_r;
    state_type s_nxt;
    logic      rst_meta_r;
    logic      rst_sync_r;
    logic [13:0] limit;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // Run-time decode
    // ----------------------------------------
    always_comb
    begin
        case (s_r.run_time[7:6])
            2'b01:   limit = LONG_RUN_01;
            2'b10:   limit = LONG_RUN_10;
            2'b11:   limit = LONG_RUN_11;
            default: limit = 14'(14'(s_r.run_time[5:0]) * 14'(CYCLES_PER_STEP));
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.count_clear = 1'b0;
        s_nxt.illegal = 1'b0;
        if (mrw_valid && mr_addr == ADDR_TERMINATION)
        begin
            // Upper two bits are dropped on the floor
            if (write_target_set_point)
                s_nxt.term_sp1 = mr_wdata[5:0];
            else
                s_nxt.term_sp0 = mr_wdata[5:0];
            // Flag codes 1,3,5,6 while the io bit is clear; value is still stored
            s_nxt.illegal = !io_pull_up_cal && (mr_wdata[2:0] == 3'h1 || mr_wdata[2:0] == 3'h3
                            || mr_wdata[2:0] == 3'h5 || mr_wdata[2:0] == 3'h6);
        end
        else if (mrw_valid && mr_addr == ADDR_RUN_TIME)
        begin
            s_nxt.run_time = mr_wdata;
        end
        if (mrr_valid)
        begin
            s_nxt.rvalid = 1'b1;
            if (mr_addr == ADDR_TERMINATION)
                s_nxt.rdata = {2'b00, write_target_set_point ? s_r.term_sp1 : s_r.term_sp0};
            else if (mr_addr == ADDR_RUN_TIME)
                s_nxt.rdata = s_r.run_time;
            else
                s_nxt.rdata = 8'h00;
        end
        s_nxt.active = operating_set_point ? s_nxt.term_sp1 : s_nxt.term_sp0;
        // Timer: start restarts count and clears reported oscillator count
        if (osc_start)
        begin
            s_nxt.running = 1'b1;
            s_nxt.elapsed = 14'h0001;
            s_nxt.count_clear = 1'b1;
        end
        else if (s_r.running)
        begin
            if (s_r.run_time == 8'h00)
            begin
                // Stop command only honoured in run-until-stopped mode
                if (mpc_valid && mpc_opcode == OPC_STOP_OSC)
                    s_nxt.running = 1'b0;
            end
            else if (s_r.elapsed >= limit)
                s_nxt.running = 1'b0;
            else
                s_nxt.elapsed = 14'(s_r.elapsed + 14'h0001);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            s_r <= '0;
            s_r.term_sp0 <= TERM_RESET[5:0];
            s_r.term_sp1 <= TERM_RESET[5:0];
            s_r.run_time <= RUN_TIME_RESET;
        end
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb
    begin
        mr_rdata = s_r.rdata;
        mr_rvalid = s_r.rvalid;
        controller_termination_value = s_r.active[CTV_LSB +: 3];
        clock_termination_disable = s_r.active[CK_DIS_BIT];
        chip_select_termination_disable = s_r.active[CS_DIS_BIT];
        command_address_termination_disable = s_r.active[CA_DIS_BIT];
        osc_running = s_r.running;
        osc_count_clear = s_r.count_clear;
        illegal_term_write = s_r.illegal;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_short_run_stop: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (osc_start && s_r.run_time == 8'h03 && !mrw_valid) ##1 (!osc_start)[*8] |-> osc_running)
        else $error("timer stopped too early");
    a_stop_cmd_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (s_r.running && s_r.run_time == 8'h00 && mpc_valid && mpc_opcode == OPC_STOP_OSC && !osc_start)
        |=> !osc_running)
        else $error("stop command ignored");
    a_zero_keeps_run: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (s_r.running && s_r.run_time == 8'h00 && !mpc_valid) |=> osc_running)
        else $error("zero code timer stopped alone");
    a_start_clears: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        osc_start |=> osc_count_clear && osc_running)
        else $error("start did not clear count");
    a_active_copy: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        ##1 controller_termination_value == ($past(operating_set_point) ? s_r.term_sp1[2:0] : s_r.term_sp0[2:0]))
        else $error("wrong set point drives termination");
    a_write_target: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (mrw_valid && mr_addr == ADDR_TERMINATION && write_target_set_point) |=> s_r.term_sp0 == $past(s_r.term_sp0))
        else $error("inactive write copy changed");
    a_disable_bits: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (mrw_valid && mr_addr == ADDR_TERMINATION && write_target_set_point == operating_set_point
         && $stable(operating_set_point)) ##1 $stable(operating_set_point)
        |-> clock_termination_disable == $past(mr_wdata[CK_DIS_BIT]))
        else $error("clock termination bit mismatch");
    a_long_limit: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (s_r.running && s_r.run_time[7:6] == 2'b01 && s_r.elapsed == 14'h0800 && !osc_start) |=> !osc_running)
        else $error("2048 clock stop missed");
    a_top_limit: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (s_r.running && s_r.run_time[7:6] == 2'b11 && s_r.elapsed == LONG_RUN_11 && !osc_start) |=> !osc_running)
        else $error("8192 clock stop missed");
    // A legal code must never be flagged, or the controller would retrain for nothing
    a_legal_quiet: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        (mrw_valid && mr_addr == ADDR_TERMINATION && io_pull_up_cal) |=> !illegal_term_write)
        else $error("legal termination code flagged");
    a_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        mrr_valid |=> mr_rvalid)
        else $error("read not answered");
endmodule

//--- design/odt_timer_pkg.sv
// Constants for the termination and oscillator run-time mode registers.
// Assumes a mode-register command decoder upstream that delivers one-cycle strobes.
package odt_timer_pkg;
    localparam logic [5:0] ADDR_RESERVED_15   = 6'h15;
    localparam logic [5:0] ADDR_TERMINATION   = 6'h16;
    localparam logic [5:0] ADDR_RUN_TIME      = 6'h17;
    localparam logic [7:0] TERM_RESET         = 8'h00;
    localparam logic [7:0] RUN_TIME_RESET     = 8'h00;
    localparam logic [6:0] OPC_STOP_OSC       = 7'h4D;
    localparam int         CTV_LSB            = 0;
    localparam int         CK_DIS_BIT         = 3;
    localparam int         CS_DIS_BIT         = 4;
    localparam int         CA_DIS_BIT         = 5;
    localparam int         CYCLES_PER_STEP    = 16;
    localparam logic [13:0] LONG_RUN_01       = 14'h0800;
    localparam logic [13:0] LONG_RUN_10       = 14'h1000;
    localparam logic [13:0] LONG_RUN_11       = 14'h2000;
endpackage

//--- testbench/mc_model.sv
// Memory controller model: mode-register and multi-purpose command strobes.
// Assumes the design samples every strobe on the rising edge of ref_clk.
`timescale 1ns/1ps
module mc_model
(
    input  wire logic ref_clk,
    output logic       mrw_valid,
    output logic       mrr_valid,
    output logic [5:0] mr_addr,
    output logic [7:0] mr_wdata,
    output logic       mpc_valid,
    output logic [6:0] mpc_opcode,
    output logic       osc_start
);
    logic [7:0] run_shadow;
    initial
    begin
        {mrw_valid, mrr_valid, mpc_valid, osc_start} = 4'h0;
        mr_addr = 6'h00;
        mr_wdata = 8'h00;
        mpc_opcode = 7'h00;
        run_shadow = 8'h00;
    end
    // One-cycle strobe; a full idle edge follows so calls may run back to back
    task automatic cmd(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        mrw_valid <= w;
        mrr_valid <= r;
        mr_addr <= a;
        mr_wdata <= d;
        @(posedge ref_clk);
        mrw_valid <= 1'b0;
        mrr_valid <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        if (a == 6'h17)
            run_shadow = d;
        cmd(1'b1, 1'b0, a, (a == 6'h16) ? (d & 8'h3F) : d);
    endtask
    task automatic strobe(input logic stop);
        @(posedge ref_clk);
        if (stop && run_shadow == 8'h00)
        begin
            mpc_valid <= 1'b1;
            mpc_opcode <= 7'h4D;
        end
        if (!stop)
            osc_start <= 1'b1;
        @(posedge ref_clk);
        mpc_valid <= 1'b0;
        mpc_opcode <= 7'h00;
        osc_start <= 1'b0;
        #1;
    endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the termination and run-time mode registers.
// Assumes the controller model drives all command strobes.
`timescale 1ns/1ps
module tb;
    import odt_timer_pkg::*;
    logic ref_clk, nrst, mrw_valid, mrr_valid, mpc_valid, osc_start, write_target_set_point;
    logic operating_set_point, io_pull_up_cal, mr_rvalid, clock_termination_disable, osc_running;
    logic chip_select_termination_disable, command_address_termination_disable, osc_count_clear;
    logic illegal_term_write;
    logic [5:0] mr_addr;
    logic [7:0] mr_wdata, mr_rdata;
    logic [6:0] mpc_opcode;
    logic [2:0] controller_termination_value;
    int n_fail, n_compared, n;
    mc_model m (
        .ref_clk    (ref_clk),
        .mrw_valid  (mrw_valid),
        .mrr_valid  (mrr_valid),
        .mr_addr    (mr_addr),
        .mr_wdata   (mr_wdata),
        .mpc_valid  (mpc_valid),
        .mpc_opcode (mpc_opcode),
        .osc_start  (osc_start)
    );
    odt_and_dqs_timer_mode_regs dut (
        .ref_clk                             (ref_clk),
        .nrst                                (nrst),
        .mrw_valid                           (mrw_valid),
        .mrr_valid                           (mrr_valid),
        .mr_addr                             (mr_addr),
        .mr_wdata                            (mr_wdata),
        .write_target_set_point              (write_target_set_point),
        .operating_set_point                 (operating_set_point),
        .io_pull_up_cal                      (io_pull_up_cal),
        .mpc_valid                           (mpc_valid),
        .mpc_opcode                          (mpc_opcode),
        .osc_start                           (osc_start),
        .mr_rdata                            (mr_rdata),
        .mr_rvalid                           (mr_rvalid),
        .controller_termination_value        (controller_termination_value),
        .clock_termination_disable           (clock_termination_disable),
        .chip_select_termination_disable     (chip_select_termination_disable),
        .command_address_termination_disable (command_address_termination_disable),
        .osc_running                         (osc_running),
        .osc_count_clear                     (osc_count_clear),
        .illegal_term_write                  (illegal_term_write)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic outs(input logic [5:0] exp);
        chk({10'h000, command_address_termination_disable, chip_select_termination_disable,
             clock_termination_disable, controller_termination_value}, {10'h000, exp});
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        m.cmd(1'b0, 1'b1, a, 8'h00);
        chk(mr_rvalid, 1'b1);
        chk(mr_rdata, exp);
    endtask
    task automatic run(input logic [7:0] code, input logic [15:0] exp);
        m.wr(ADDR_RUN_TIME, code);
        m.strobe(1'b0);
        chk(osc_count_clear, 1'b1);
        n = 0;
        while (osc_running === 1'b1 && n < 9000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n, exp);
    endtask
    task automatic results;
        $display("compared %0d, wrong %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #(25 * 40000);
        n_fail++;
        results;
    end
    initial
    begin
        {n_fail, n_compared, nrst, write_target_set_point, operating_set_point, io_pull_up_cal} = 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 outs(6'h00);
        rd(ADDR_RUN_TIME, RUN_TIME_RESET);
        m.cmd(1'b1, 1'b0, ADDR_TERMINATION, 8'hFA);
        outs(6'h3A);
        chk(illegal_term_write, 1'b0);
        rd(ADDR_TERMINATION, 8'h3A);
        write_target_set_point <= 1'b1;
        m.wr(ADDR_TERMINATION, 8'h05);
        chk(illegal_term_write, 1'b1);
        outs(6'h3A);
        rd(ADDR_TERMINATION, 8'h05);
        io_pull_up_cal <= 1'b1;
        m.wr(ADDR_TERMINATION, 8'h05);
        chk(illegal_term_write, 1'b0);
        operating_set_point <= 1'b1;
        @(posedge ref_clk);
        #1 outs(6'h05);
        write_target_set_point <= 1'b0;
        rd(ADDR_TERMINATION, 8'h3A);
        rd(ADDR_RESERVED_15, 8'h00);
        $display("test termination done");
        run(8'h03, 16'h0030);
        run(8'h3F, 16'h03F0);
        run(8'h55, 16'h0800);
        run(8'hAA, 16'h1000);
        run(8'hC1, 16'h2000);
        $display("test timed runs done");
        m.wr(ADDR_RUN_TIME, 8'h00);
        m.strobe(1'b0);
        repeat (9000) @(posedge ref_clk);
        #1 chk(osc_running, 1'b1);
        m.strobe(1'b1);
        chk(osc_running, 1'b0);
        $display("test stop command done");
        results;
    end
endmodule
